// file: logic/adc_channel0_input_select_scan.v
`timescale 1ns/1ps
`default_nettype none
`include "input_select_defines.vh"

module adc_channel0_input_select_scan #(
  parameter SMALL_VARIANT = 0
) (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire [`ISEL_ADDR_W-1:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  input wire i_converter_module_disable,
  input wire i_scan_enable_sample_a,
  input wire i_alternate_sample_enable,
  input wire i_sample_done,
  output reg [4:0] o_pos_input,
  output reg o_neg_is_an1,
  output reg o_sample_is_b,
  output reg [8:0] o_port_read_enable,
  output reg [8:0] o_mux_to_ground
);

  localparam [8:0] PRESENT = (SMALL_VARIANT != 0) ? 9'h03f : 9'h1ff;
  localparam [4:0] MAX_POS = (SMALL_VARIANT != 0) ?
    `ISEL_MAX_POS_SMALL : `ISEL_MAX_POS_LARGE;

  reg [15:0] ch0_select_reg;
  reg [15:0] scan_select_reg;
  reg [15:0] pin_config_reg;
  reg sample_b_reg;
  reg [4:0] pos_next;
  reg neg_next;
  wire [3:0] scan_idx;
  wire scan_none;
  wire [8:0] pin_digital;

  // map a select code to a mux code, absent inputs become the low reference
  function [4:0] pos_code;
    input [4:0] code;
    begin
      if (code <= MAX_POS && PRESENT[code[3:0]]) begin
        pos_code = code;
      end else begin
        pos_code = `ISEL_POS_LOW_REF;
      end
    end
  endfunction

  // ===========================================================
  // register port
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ch0_select_reg <= `ISEL_CH0_RST;
      scan_select_reg <= `ISEL_SCAN_RST;
      pin_config_reg <= `ISEL_PIN_ANALOG_DIGITAL_BITS_RST;
      o_rdata <= 16'h0000;
    end else if (i_ce) begin
      if (i_wr) begin
        case (i_addr)
          `ISEL_OFF_CH0: begin
            ch0_select_reg <= i_wdata & `ISEL_CH0_MASK;
          end
          `ISEL_OFF_SCAN: begin
            scan_select_reg <= i_wdata & `ISEL_AN_MASK;
          end
          `ISEL_OFF_PIN_ANALOG_DIGITAL_BITS: begin
            pin_config_reg <= i_wdata & `ISEL_AN_MASK;
          end
          default: begin
          end
        endcase
      end
      o_rdata <= 16'h0000;
      if (i_rd) begin
        case (i_addr)
          `ISEL_OFF_CH0: o_rdata <= ch0_select_reg;
          `ISEL_OFF_SCAN: o_rdata <= scan_select_reg;
          `ISEL_OFF_PIN_ANALOG_DIGITAL_BITS: o_rdata <= pin_config_reg;
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ===========================================================
  // scan sequence
  scan_sequencer u_scan (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_restart(~i_scan_enable_sample_a),
    .i_step(i_sample_done & ~sample_b_reg),
    .i_scan_bits(scan_select_reg[8:0]),
    .o_index(scan_idx),
    .o_none(scan_none)
  );

  // ===========================================================
  // sample slot and input selection
  always @* begin
    if (sample_b_reg) begin
      pos_next = pos_code(
        ch0_select_reg[`ISEL_POS_B_HI:`ISEL_POS_B_LO]);
      neg_next = ch0_select_reg[`ISEL_NEG_B_BIT];
    end else if (i_scan_enable_sample_a) begin
      // before the first step the index may rest on an unselected input
      if (scan_none || scan_idx > 4'h8 ||
          !scan_select_reg[scan_idx]) begin
        pos_next = `ISEL_POS_LOW_REF;
      end else begin
        pos_next = pos_code({1'b0, scan_idx});
      end
      neg_next = ch0_select_reg[`ISEL_NEG_A_BIT];
    end else begin
      pos_next = pos_code(
        ch0_select_reg[`ISEL_POS_A_HI:`ISEL_POS_A_LO]);
      neg_next = ch0_select_reg[`ISEL_NEG_A_BIT];
    end
  end

  // digital when bit set or converter disabled; absent pins stay digital
  assign pin_digital = ({9{i_converter_module_disable}} |
    pin_config_reg[8:0] | ~PRESENT);

  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      sample_b_reg <= 1'b0;
      o_pos_input <= 5'h00;
      o_neg_is_an1 <= 1'b0;
      o_sample_is_b <= 1'b0;
      o_port_read_enable <= 9'h1ff;
      o_mux_to_ground <= 9'h1ff;
    end else if (i_ce) begin
      if (!i_alternate_sample_enable) begin
        sample_b_reg <= 1'b0;
      end else if (i_sample_done) begin
        sample_b_reg <= ~sample_b_reg;
      end
      o_pos_input <= pos_next;
      o_neg_is_an1 <= neg_next;
      o_sample_is_b <= sample_b_reg;
      o_port_read_enable <= pin_digital;
      o_mux_to_ground <= pin_digital;
    end
  end

endmodule
`default_nettype wire

// file: logic/input_select_defines.vh
`ifndef INPUT_SELECT_DEFINES_VH
`define INPUT_SELECT_DEFINES_VH

// register offsets on the plain register port
`define ISEL_ADDR_W 4
`define ISEL_OFF_CH0 4'h0
`define ISEL_OFF_SCAN 4'h1
`define ISEL_OFF_PIN_ANALOG_DIGITAL_BITS 4'h2

// channel 0 select field positions
`define ISEL_NEG_B_BIT 15
`define ISEL_POS_B_HI 12
`define ISEL_POS_B_LO 8
`define ISEL_NEG_A_BIT 7
`define ISEL_POS_A_HI 4
`define ISEL_POS_A_LO 0
`define ISEL_CH0_MASK 16'h9f9f

// nine-bit scan and pin fields
`define ISEL_NUM_AN 9
`define ISEL_AN_MASK 16'h01ff

// reset values
`define ISEL_CH0_RST 16'h0000
`define ISEL_SCAN_RST 16'h0000
`define ISEL_PIN_ANALOG_DIGITAL_BITS_RST 16'h0000

// highest positive select code per variant
`define ISEL_MAX_POS_LARGE 5'h08
`define ISEL_MAX_POS_SMALL 5'h05

// positive mux code for the low reference
`define ISEL_POS_LOW_REF 5'h1f

`endif

// file: logic/scan_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "input_select_defines.vh"

// steps round the inputs whose scan bit is set, one step per slot A sample pulse
module scan_sequencer (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire i_restart,
  input wire i_step,
  input wire [8:0] i_scan_bits,
  output wire [3:0] o_index,
  output wire o_none
);

  reg [3:0] idx_reg;
  reg [3:0] idx_next;
  integer k;
  integer nxt;
  reg found;

  // ===========================================================
  // next selected input after the current one, wrapping round
  always @* begin
    idx_next = idx_reg;
    found = 1'b0;
    nxt = 0;
    for (k = 1; k <= `ISEL_NUM_AN; k = k + 1) begin
      nxt = (idx_reg + k) % `ISEL_NUM_AN;
      if (!found && i_scan_bits[nxt]) begin
        idx_next = nxt[3:0];
        found = 1'b1;
      end
    end
  end

  // ===========================================================
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      idx_reg <= 4'h0;
    end else if (i_ce) begin
      if (i_restart) begin
        idx_reg <= 4'h8;
      end else if (i_step) begin
        idx_reg <= idx_next;
      end
    end
  end

  assign o_index = idx_reg;
  assign o_none = ~|i_scan_bits;

endmodule
`default_nettype wire

// file: test/conv_core.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// converter core: one sample-finished pulse per request
module conv_core (
  input wire i_clk,
  input wire i_req,
  output logic o_sample_done
);
  initial o_sample_done = 1'h0;
  always @(posedge i_clk) o_sample_done <= i_req;
endmodule
`default_nettype wire

// file: test/input_select_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// register port and mux control checker
module input_select_chk (
  input wire i_sys_clk,
  input wire i_rst_b,
  input wire i_ce,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire i_converter_module_disable,
  input wire i_scan_enable_sample_a,
  input wire i_alternate_sample_enable,
  input wire i_sample_done,
  input wire [4:0] o_pos_input,
  input wire o_neg_is_an1,
  input wire o_sample_is_b,
  input wire [8:0] o_port_read_enable,
  input wire [8:0] o_mux_to_ground
);
  wire quiet = !i_alternate_sample_enable && !i_scan_enable_sample_a;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b || !i_ce);
  ch0_readback_a: assert property (
    i_wr && i_addr == 4'h0 ##1 !i_wr ##1 i_rd && i_addr == 4'h0 |=>
    o_rdata == ($past(i_wdata, 3) & 16'h9f9f)) else $error("ch0 read");
  pin_analog_digital_bits_readback_a: assert property (
    i_wr && i_addr == 4'h2 ##1 !i_wr ##1 i_rd && i_addr == 4'h2 |=>
    o_rdata == ($past(i_wdata, 3) & 16'h01ff)) else $error("pin read");
  scan_upper_zero_a: assert property (
    i_rd && i_addr == 4'h1 |=> o_rdata[15:9] == 7'h00)
    else $error("scan upper");
  slot_a_route_a: assert property (
    quiet [*3] ##0 i_wr && i_addr == 4'h0 ##1 quiet |=>
    o_neg_is_an1 == $past(i_wdata[7], 2) && o_pos_input ==
    ($past(i_wdata[4:0], 2) > 5'h08 ? 5'h1f : $past(i_wdata[4:0], 2)))
    else $error("slot a route");
  pin_mode_a: assert property (
    !i_converter_module_disable [*3] ##0 i_wr && i_addr == 4'h2 ##1
    !i_converter_module_disable |=> o_port_read_enable ==
    $past(i_wdata[8:0], 2) && o_mux_to_ground == $past(i_wdata[8:0], 2))
    else $error("pin mode");
  all_digital_a: assert property (
    i_converter_module_disable [*2] |=> o_port_read_enable == 9'h1ff &&
    o_mux_to_ground == 9'h1ff) else $error("pins not digital");
  slot_toggle_a: assert property (
    i_alternate_sample_enable && i_sample_done |=>
    ##1 $changed(o_sample_is_b)) else $error("slot stuck");
  slot_a_only_a: assert property (
    !i_alternate_sample_enable [*3] |-> !o_sample_is_b) else $error("slot b");
endmodule
bind adc_channel0_input_select_scan input_select_chk u_input_select_chk (.*);
`default_nettype wire

// file: test/tb_adc_channel0_input_select_scan.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("mismatch %s exp %h got %h", n, e, g); end
// ==========
// bench
module tb_adc_channel0_input_select_scan;
  logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, req = 1'h0;
  logic dis = 1'h0, scan = 1'h0, alt = 1'h0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  wire [15:0] rdata;
  wire [4:0] pos;
  wire neg, is_b, done;
  wire [8:0] dig, gnd;
  int failures = 0;
  int samples_checked = 0;
  initial forever #2 clk = ~clk;
  adc_channel0_input_select_scan u_adc_channel0_input_select_scan (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_ce(1'h1), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_converter_module_disable(dis), .i_scan_enable_sample_a(scan),
    .i_alternate_sample_enable(alt), .i_sample_done(done),
    .o_pos_input(pos), .o_neg_is_an1(neg), .o_sample_is_b(is_b),
    .o_port_read_enable(dig), .o_mux_to_ground(gnd));
  conv_core u_conv_core (.i_clk(clk), .i_req(req), .o_sample_done(done));
  task automatic complete_run;
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr_reg(input [3:0] a, input [15:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input [3:0] a, input [15:0] e);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 `CHK("rdata", e, rdata)
  endtask
  // one finished sample from the core, then let the outputs settle
  task automatic pulse;
    @(posedge clk);
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    logic [15:0] mask [3] = '{16'h9f9f, 16'h01ff, 16'h01ff};
    for (int i = 0; i < 3; i++) begin
      rd_chk(i[3:0], 16'h0000);
      wr_reg(i[3:0], 16'hffff);
      rd_chk(i[3:0], mask[i]);
    end
    wr_reg(4'h3, 16'hffff);
    rd_chk(4'h3, 16'h0000);
  endtask
  task automatic t_route;
    wr_reg(4'h0, 16'h8308);
    pulse;
    `CHK("pos a", 5'h08, pos)
    `CHK("neg a", 1'h0, neg)
    @(posedge clk);
    alt <= 1'h1;
    pulse;
    `CHK("slot", 1'h1, is_b)
    `CHK("pos b", 5'h03, pos)
    `CHK("neg b", 1'h1, neg)
    pulse;
    `CHK("pos a", 5'h08, pos)
    @(posedge clk);
    alt <= 1'h0;
  endtask
  task automatic t_scan;
    wr_reg(4'h1, 16'h0024);
    @(posedge clk);
    scan <= 1'h1;
    pulse;
    `CHK("scan", 5'h02, pos)
    pulse;
    `CHK("scan", 5'h05, pos)
    pulse;
    `CHK("scan", 5'h02, pos)
    @(posedge clk);
    scan <= 1'h0;
  endtask
  task automatic t_pins;
    wr_reg(4'h2, 16'h0155);
    pulse;
    `CHK("dig", 9'h155, dig)
    `CHK("gnd", 9'h155, gnd)
    @(posedge clk);
    dis <= 1'h1;
    pulse;
    `CHK("off", 9'h1ff, dig)
    `CHK("off gnd", 9'h1ff, gnd)
    @(posedge clk);
    dis <= 1'h0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    t_regs;
    t_route;
    t_scan;
    t_pins;
    complete_run;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    complete_run;
  end
endmodule
`default_nettype wire
